// ==== logic/phy_mgmt_consts.vh ====
// constants for the phy management register view of the two line ports
// assumes inclusion by phy_mgmt_register_map.v and phy_port_control.v only
`ifndef PHY_MGMT_CONSTS_VH
`define PHY_MGMT_CONSTS_VH

// management register indices inside one phy
`define MII_CTRL 5'h00
`define MII_STATUS 5'h01
`define MII_ID_HIGH 5'h02
`define MII_ID_LOW 5'h03
`define MII_ADV 5'h04
`define MII_PARTNER 5'h05
`define MII_DIAG 5'h1D
`define MII_SPECIAL 5'h1F

// basic control bit positions
`define CB_LOOP 14
`define CB_F100 13
`define CB_AN 12
`define CB_PD 11
`define CB_RESTART 9
`define CB_FDX 8
`define CB_XOVER 5
`define CB_MDI 4
// special control bit position
`define SP_NEAR 1

// switch register bit positions
`define SW_NEAR_BIT 1
`define SW_F100_BIT 6
`define SW_AN_BIT 7
`define SW_FDX_BIT 5
`define SW_LOOP_BIT 0
`define SW_PD_BIT 3
`define SW_RESTART_BIT 5
`define SW_MDI_BIT 1
`define SW_XOVER_BIT 7

// switch register offsets
`define GC13_REG 8'h0F
`define GC13_RESET 8'h08
`define ADDR_FIELD_HI 7
`define ADDR_FIELD_LO 3
`define P1_NEAR_REG 8'h1A
`define P1_MODE_REG 8'h1C
`define P1_CTRL_REG 8'h1D
`define P1_XOVER_REG 8'h1F
`define P2_NEAR_REG 8'h2A
`define P2_MODE_REG 8'h2C
`define P2_CTRL_REG 8'h2D
`define P2_XOVER_REG 8'h2F

// management frame framing
`define MDIO_PRE_LEN 6'h20
`define MDIO_HDR_LAST 6'h0C
`define MDIO_TA_LAST 6'h01
`define MDIO_DAT_LAST 6'h0F
`define MDIO_OP_RD 2'h2
`define MDIO_OP_WR 2'h1

// reset values
`define AN_RESET 1'b1
`define XOVER_RESET 1'b1
`define WORD_ZERO 16'h0000
`define BYTE_ZERO 8'h00

`endif

// ==== logic/phy_port_control.v ====
// control bits of one phy port, shared by the management and switch views
// assumes writes arrive as single-cycle strobes on clk_i
`timescale 1ns/100ps
`include "phy_mgmt_consts.vh"

module phy_port_control #(
    parameter [7:0] NEAR_REG = `P1_NEAR_REG,
    parameter [7:0] MODE_REG = `P1_MODE_REG,
    parameter [7:0] CTRL_REG = `P1_CTRL_REG,
    parameter [7:0] XOVER_REG = `P1_XOVER_REG,
    parameter [15:0] ADV_RESET = 16'h0000
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // management view write
    input wire mii_wr_i,
    input wire [4:0] mii_reg_i,
    input wire [15:0] mii_wdata_i,
    // switch view access
    input wire sw_wr_i,
    input wire [7:0] sw_addr_i,
    input wire [7:0] sw_wdata_i,
    output reg [7:0] sw_rdata_o,
    // register words
    output reg [15:0] ctrl_word_o,
    output reg [15:0] adv_o,
    output reg [15:0] diag_o,
    output reg [15:0] special_o,
    // control levels
    output reg near_loop_o,
    output reg far_loop_o,
    output reg force_100_o,
    output reg autoneg_on_o,
    output reg power_down_o,
    output reg autoneg_restart_o,
    output reg full_duplex_o,
    output reg crossover_algorithm_select_o,
    output reg force_straight_through_o
);

wire mw_ctrl = mii_wr_i && (mii_reg_i == `MII_CTRL);
wire mw_adv = mii_wr_i && (mii_reg_i == `MII_ADV);
wire mw_diag = mii_wr_i && (mii_reg_i == `MII_DIAG);
wire mw_spec = mii_wr_i && (mii_reg_i == `MII_SPECIAL);
wire sw_near = sw_wr_i && (sw_addr_i == NEAR_REG);
wire sw_mode = sw_wr_i && (sw_addr_i == MODE_REG);
wire sw_ctrl = sw_wr_i && (sw_addr_i == CTRL_REG);
wire sw_xover = sw_wr_i && (sw_addr_i == XOVER_REG);

// switch view applied after management view: same-cycle writes favour the switch port, except restart, which either view can pulse
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        near_loop_o <= 1'b0;
        far_loop_o <= 1'b0;
        force_100_o <= 1'b0;
        autoneg_on_o <= `AN_RESET;
        power_down_o <= 1'b0;
        autoneg_restart_o <= 1'b0;
        full_duplex_o <= 1'b0;
        crossover_algorithm_select_o <= `XOVER_RESET;
        force_straight_through_o <= 1'b0;
        adv_o <= ADV_RESET;
        diag_o <= `WORD_ZERO;
    end else begin
        if (mw_ctrl) begin
            far_loop_o <= mii_wdata_i[`CB_LOOP]; // RULE10
            force_100_o <= mii_wdata_i[`CB_F100]; // RULE15
            autoneg_on_o <= mii_wdata_i[`CB_AN]; // RULE11
            power_down_o <= mii_wdata_i[`CB_PD]; // RULE15
            full_duplex_o <= mii_wdata_i[`CB_FDX]; // RULE15
            crossover_algorithm_select_o <= mii_wdata_i[`CB_XOVER]; // RULE13
            force_straight_through_o <= mii_wdata_i[`CB_MDI]; // RULE14
        end
        if (mw_spec) begin
            near_loop_o <= mii_wdata_i[`SP_NEAR]; // RULE3
        end
        if (sw_near) begin
            near_loop_o <= sw_wdata_i[`SW_NEAR_BIT]; // RULE2
        end
        if (sw_mode) begin
            force_100_o <= sw_wdata_i[`SW_F100_BIT]; // RULE9
            autoneg_on_o <= sw_wdata_i[`SW_AN_BIT];
            full_duplex_o <= sw_wdata_i[`SW_FDX_BIT];
        end
        if (sw_ctrl) begin
            far_loop_o <= sw_wdata_i[`SW_LOOP_BIT]; // RULE9
            power_down_o <= sw_wdata_i[`SW_PD_BIT];
            force_straight_through_o <= sw_wdata_i[`SW_MDI_BIT];
        end
        if (sw_xover) begin
            crossover_algorithm_select_o <= sw_wdata_i[`SW_XOVER_BIT]; // RULE9
        end
        // restart is a one-cycle pulse, so it reads back as zero once taken
        autoneg_restart_o <= (mw_ctrl && mii_wdata_i[`CB_RESTART]) ||
            (sw_ctrl && sw_wdata_i[`SW_RESTART_BIT]); // RULE12
        if (mw_adv) begin
            adv_o <= mii_wdata_i;
        end
        if (mw_diag) begin
            diag_o <= mii_wdata_i;
        end
    end
end

// unimplemented control bits stay zero
always @* begin
    ctrl_word_o = `WORD_ZERO; // RULE16
    ctrl_word_o[`CB_LOOP] = far_loop_o;
    ctrl_word_o[`CB_F100] = force_100_o;
    ctrl_word_o[`CB_AN] = autoneg_on_o;
    ctrl_word_o[`CB_PD] = power_down_o;
    ctrl_word_o[`CB_RESTART] = autoneg_restart_o;
    ctrl_word_o[`CB_FDX] = full_duplex_o;
    ctrl_word_o[`CB_XOVER] = crossover_algorithm_select_o;
    ctrl_word_o[`CB_MDI] = force_straight_through_o;
    special_o = `WORD_ZERO;
    special_o[`SP_NEAR] = near_loop_o;
end

// switch view: only the mirrored bits exist here, the rest read zero
always @* begin
    sw_rdata_o = `BYTE_ZERO;
    if (sw_addr_i == NEAR_REG) begin
        sw_rdata_o[`SW_NEAR_BIT] = near_loop_o;
    end else if (sw_addr_i == MODE_REG) begin
        sw_rdata_o[`SW_F100_BIT] = force_100_o;
        sw_rdata_o[`SW_AN_BIT] = autoneg_on_o;
        sw_rdata_o[`SW_FDX_BIT] = full_duplex_o;
    end else if (sw_addr_i == CTRL_REG) begin
        sw_rdata_o[`SW_LOOP_BIT] = far_loop_o;
        sw_rdata_o[`SW_PD_BIT] = power_down_o;
        sw_rdata_o[`SW_RESTART_BIT] = autoneg_restart_o;
        sw_rdata_o[`SW_MDI_BIT] = force_straight_through_o;
    end else if (sw_addr_i == XOVER_REG) begin
        sw_rdata_o[`SW_XOVER_BIT] = crossover_algorithm_select_o;
    end
end

endmodule // phy_port_control

// ==== logic/phy_mgmt_register_map.v ====
// management register view of the two line phys, with loopback data paths
// assumes mdc_i/mdio_i come from off-chip; switch port and line data on clk_i
//
// Behaviour
// RULE1: near loopback sends a port's received symbols back out its own transmit.
// RULE2: switch registers 26/42 bit 1 enable near loopback for ports 1/2.
// RULE3: management register 31 bit 1 also enables near loopback for its port.
// RULE4: far party sets both ports to 100 Mbit twisted pair before loopback.
// RULE5: after reset ports 1 and 2 answer at phy addresses 1 and 2.
// RULE6: global register 0x0F bits 7..3 reprogram the phy addresses.
// RULE7: indices 0..5, 0x1D and 0x1F exist per phy; others unsupported.
// RULE8: index 0 control, 1 status, 2/3 ids, 4/5 autoneg, 0x1F special.
// RULE9: switch and management views share one copy of each control bit.
// RULE10: control bit 14 loops the other port through this phy; aliases 29/45 bit 0.
// RULE11: control bit 12 enables autoneg, resets to 1, aliases 28/44 bit 7.
// RULE12: writing 1 to control bit 9 restarts autoneg; aliases 29/45 bit 5.
// RULE13: control bit 5 picks crossover algorithm, resets 1, aliases 31/47 bit 7.
// RULE14: control bit 4 forces straight-through transmit; aliases 29/45 bit 1.
// RULE15: bits 13, 11, 8 force 100, power down, full duplex; reset 0.
// RULE16: control bits 15, 10, 7, 6 read zero and ignore writes.
// RULE17: unsupported indices read zero and ignore writes.
`timescale 1ns/100ps
`include "phy_mgmt_consts.vh"

module phy_mgmt_register_map #(
    parameter SYM_W = 5,
    parameter [15:0] ID_HIGH = 16'h0000, // arbitrary value
    parameter [15:0] ID_LOW = 16'h0000, // arbitrary value
    parameter [15:0] ADV_RESET = 16'h0001
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // management link
    input wire mdc_i,
    input wire mdio_i,
    output reg mdio_o,
    output reg mdio_oe_o,
    // switch register port
    input wire sw_wr_i,
    input wire [7:0] sw_addr_i,
    input wire [7:0] sw_wdata_i,
    output reg [7:0] sw_rdata_o,
    // line symbol paths, port 1 in the low slice
    input wire [2*SYM_W-1:0] line_receive_pair_i,
    input wire [2*SYM_W-1:0] mac_transmit_i,
    output reg [2*SYM_W-1:0] line_transmit_pair_o,
    // phy status words, port 1 in the low half
    input wire [31:0] basic_status_i,
    input wire [31:0] partner_ability_i,
    // per-port controls, bit 0 is port 1
    output wire [1:0] near_loop_o,
    output wire [1:0] far_loop_o,
    output wire [1:0] force_100_o,
    output wire [1:0] autoneg_on_o,
    output wire [1:0] autoneg_restart_o,
    output wire [1:0] power_down_o,
    output wire [1:0] full_duplex_o,
    output wire [1:0] crossover_algorithm_select_o,
    output wire [1:0] force_straight_through_o
);

localparam S_PRE = 4'b0001;
localparam S_HDR = 4'b0010;
localparam S_TA = 4'b0100;
localparam S_DAT = 4'b1000;

// pin synchronisers, the third mdc stage only finds the edge
reg mdc_s1;
reg mdc_s2;
reg mdc_s3;
reg mdio_s1;
reg mdio_s2;
wire mdc_rise = mdc_s2 && !mdc_s3;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        mdc_s1 <= 1'b0;
        mdc_s2 <= 1'b0;
        mdc_s3 <= 1'b0;
        mdio_s1 <= 1'b1;
        mdio_s2 <= 1'b1;
    end else begin
        mdc_s1 <= mdc_i;
        mdc_s2 <= mdc_s1;
        mdc_s3 <= mdc_s2;
        mdio_s1 <= mdio_i;
        mdio_s2 <= mdio_s1;
    end
end

// global control 13 holds the phy address field
reg [7:0] gc13;
wire [4:0] base_addr = gc13[`ADDR_FIELD_HI:`ADDR_FIELD_LO];
wire [4:0] port2_addr = base_addr + 5'h01;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        gc13 <= `GC13_RESET; // RULE5
    end else if (sw_wr_i && sw_addr_i == `GC13_REG) begin
        gc13 <= sw_wdata_i; // RULE6
    end
end

// frame engine state
reg [3:0] state;
reg [5:0] cnt;
reg [15:0] shf;
reg [4:0] reg_idx;
reg [1:0] hit;
reg is_rd;
reg is_wr;
reg mii_wr;
reg [15:0] mii_wdata;
wire [12:0] hdr = {shf[11:0], mdio_s2};
wire [4:0] hdr_phy = hdr[9:5];
wire [15:0] rd_word;

always @(posedge clk_i) begin
    if (!rst_n_i) begin
        state <= S_PRE;
        cnt <= 6'h00;
        shf <= `WORD_ZERO;
        reg_idx <= 5'h00;
        hit <= 2'b00;
        is_rd <= 1'b0;
        is_wr <= 1'b0;
        mii_wr <= 1'b0;
        mii_wdata <= `WORD_ZERO;
        mdio_o <= 1'b0;
        mdio_oe_o <= 1'b0;
    end else begin
        mii_wr <= 1'b0;
        if (mdc_rise) begin
            case (state)
                S_PRE: begin
                    if (mdio_s2) begin
                        if (cnt != `MDIO_PRE_LEN) begin
                            cnt <= cnt + 6'h01;
                        end
                    end else if (cnt == `MDIO_PRE_LEN) begin
                        state <= S_HDR;
                        cnt <= 6'h00;
                    end else begin
                        cnt <= 6'h00;
                    end
                end
                S_HDR: begin
                    shf <= {shf[14:0], mdio_s2};
                    cnt <= cnt + 6'h01;
                    if (cnt == `MDIO_HDR_LAST) begin
                        cnt <= 6'h00;
                        // a broken start pattern drops back to preamble hunting
                        state <= hdr[12] ? S_TA : S_PRE;
                        is_rd <= hdr[11:10] == `MDIO_OP_RD;
                        is_wr <= hdr[11:10] == `MDIO_OP_WR;
                        hit <= {hdr_phy == port2_addr, hdr_phy == base_addr}; // RULE5
                        reg_idx <= hdr[4:0];
                    end
                end
                S_TA: begin
                    cnt <= cnt + 6'h01;
                    if (is_rd && hit != 2'b00) begin
                        mdio_oe_o <= 1'b1;
                    end
                    if (cnt == `MDIO_TA_LAST) begin
                        cnt <= 6'h00;
                        state <= S_DAT;
                        shf <= {rd_word[14:0], 1'b0};
                        mdio_o <= rd_word[15];
                    end else begin
                        mdio_o <= 1'b0;
                    end
                end
                S_DAT: begin
                    cnt <= cnt + 6'h01;
                    shf <= is_rd ? {shf[14:0], 1'b0} : {shf[14:0], mdio_s2};
                    mdio_o <= shf[15];
                    if (cnt == `MDIO_DAT_LAST) begin
                        cnt <= 6'h00;
                        state <= S_PRE;
                        mdio_oe_o <= 1'b0;
                        mdio_o <= 1'b0;
                        mii_wr <= is_wr && hit != 2'b00;
                        mii_wdata <= {shf[14:0], mdio_s2};
                    end
                end
                default: begin
                    state <= S_PRE;
                    cnt <= 6'h00;
                    mdio_oe_o <= 1'b0;
                end
            endcase
        end
    end
end

// per-port banks and line paths
wire [15:0] ctrl_w [0:1];
wire [15:0] adv_w [0:1];
wire [15:0] diag_w [0:1];
wire [15:0] spec_w [0:1];
wire [7:0] sw_byte [0:1];
reg [15:0] port_word [0:1];

genvar p;
generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
        phy_port_control #(
            .NEAR_REG(p == 0 ? `P1_NEAR_REG : `P2_NEAR_REG),
            .MODE_REG(p == 0 ? `P1_MODE_REG : `P2_MODE_REG),
            .CTRL_REG(p == 0 ? `P1_CTRL_REG : `P2_CTRL_REG),
            .XOVER_REG(p == 0 ? `P1_XOVER_REG : `P2_XOVER_REG),
            .ADV_RESET(ADV_RESET)
        ) u_ctrl (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .mii_wr_i(mii_wr && hit[p]), // RULE9
            .mii_reg_i(reg_idx),
            .mii_wdata_i(mii_wdata),
            .sw_wr_i(sw_wr_i),
            .sw_addr_i(sw_addr_i),
            .sw_wdata_i(sw_wdata_i),
            .sw_rdata_o(sw_byte[p]),
            .ctrl_word_o(ctrl_w[p]),
            .adv_o(adv_w[p]),
            .diag_o(diag_w[p]),
            .special_o(spec_w[p]),
            .near_loop_o(near_loop_o[p]),
            .far_loop_o(far_loop_o[p]),
            .force_100_o(force_100_o[p]),
            .autoneg_on_o(autoneg_on_o[p]),
            .power_down_o(power_down_o[p]),
            .autoneg_restart_o(autoneg_restart_o[p]),
            .full_duplex_o(full_duplex_o[p]),
            .crossover_algorithm_select_o(crossover_algorithm_select_o[p]),
            .force_straight_through_o(force_straight_through_o[p])
        );

        // management index decode, unlisted indices read zero
        always @* begin
            case (reg_idx)
                `MII_CTRL: port_word[p] = ctrl_w[p]; // RULE8
                `MII_STATUS: port_word[p] = basic_status_i[16*p +: 16];
                `MII_ID_HIGH: port_word[p] = ID_HIGH;
                `MII_ID_LOW: port_word[p] = ID_LOW;
                `MII_ADV: port_word[p] = adv_w[p];
                `MII_PARTNER: port_word[p] = partner_ability_i[16*p +: 16];
                `MII_DIAG: port_word[p] = diag_w[p]; // RULE7
                `MII_SPECIAL: port_word[p] = spec_w[p];
                default: port_word[p] = `WORD_ZERO; // RULE17
            endcase
        end

        // near loop wraps at this phy; far loop set on the other phy wraps here too
        always @(posedge clk_i) begin
            if (!rst_n_i) begin
                line_transmit_pair_o[p*SYM_W +: SYM_W] <= {SYM_W{1'b0}};
            end else if (power_down_o[p]) begin
                line_transmit_pair_o[p*SYM_W +: SYM_W] <= {SYM_W{1'b0}};
            end else if (near_loop_o[p] || far_loop_o[1-p]) begin
                line_transmit_pair_o[p*SYM_W +: SYM_W] <=
                    line_receive_pair_i[p*SYM_W +: SYM_W]; // RULE1 RULE10
            end else begin
                line_transmit_pair_o[p*SYM_W +: SYM_W] <= mac_transmit_i[p*SYM_W +: SYM_W];
            end
        end
    end
endgenerate

// port 1 wins if both decoded addresses collide
assign rd_word = hit[0] ? port_word[0] : (hit[1] ? port_word[1] : `WORD_ZERO);

// switch read data, one cycle after the address
always @(posedge clk_i) begin
    if (!rst_n_i) begin
        sw_rdata_o <= `BYTE_ZERO;
    end else if (sw_addr_i == `GC13_REG) begin
        sw_rdata_o <= gc13;
    end else begin
        sw_rdata_o <= sw_byte[0] | sw_byte[1];
    end
end

endmodule // phy_mgmt_register_map

// ==== tb/phy_mgmt_register_map_properties.sv ====
// concurrent checks on the phy management register view ports
// assumes a bind onto phy_mgmt_register_map, port 1 in the low slices
`timescale 1ns/100ps
module phy_mgmt_register_map_properties #(
    parameter SYM_W = 5
) (
    // clock and reset
    input wire clk_i,
    input wire rst_n_i,
    // management data out
    input wire mdio_o,
    input wire mdio_oe_o,
    // switch register port
    input wire sw_wr_i,
    input wire [7:0] sw_addr_i,
    input wire [7:0] sw_wdata_i,
    input wire [7:0] sw_rdata_o,
    // line paths
    input wire [2*SYM_W-1:0] line_receive_pair_i,
    input wire [2*SYM_W-1:0] line_transmit_pair_o,
    // controls
    input wire [1:0] near_loop_o,
    input wire [1:0] far_loop_o,
    input wire [1:0] force_100_o,
    input wire [1:0] autoneg_on_o,
    input wire [1:0] autoneg_restart_o,
    input wire [1:0] power_down_o,
    input wire [1:0] full_duplex_o,
    input wire [1:0] crossover_algorithm_select_o,
    input wire [1:0] force_straight_through_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire wr_ctl1 = sw_wr_i && sw_addr_i == 8'h1D;

    reset_values_a: assert property ($rose(rst_n_i) |-> autoneg_on_o == 2'b11
        && crossover_algorithm_select_o == 2'b11 && power_down_o == 2'b00 && !mdio_oe_o)
        else $error("control reset values wrong");
    near_path_a: assert property (near_loop_o[0] && !power_down_o[0] |=>
        line_transmit_pair_o[SYM_W-1:0] == $past(line_receive_pair_i[SYM_W-1:0]))
        else $error("near loopback path wrong");
    near_alias_a: assert property (sw_wr_i && sw_addr_i == 8'h1A |=>
        near_loop_o[0] == $past(sw_wdata_i[1])) else $error("near loop alias wrong");
    mode_alias_a: assert property (sw_wr_i && sw_addr_i == 8'h1C |=>
        {autoneg_on_o[0], force_100_o[0], full_duplex_o[0]} == $past(sw_wdata_i[7:5]))
        else $error("mode alias wrong");
    restart_pulse_a: assert property (wr_ctl1 && sw_wdata_i[5] |=>
        autoneg_restart_o[0] ##1 !autoneg_restart_o[0]) else $error("restart pulse wrong");
    ctrl_alias_a: assert property (wr_ctl1 |=> far_loop_o[0] == $past(sw_wdata_i[0])
        && force_straight_through_o[0] == $past(sw_wdata_i[1])
        && power_down_o[0] == $past(sw_wdata_i[3])) else $error("control alias wrong");
    xover_alias_a: assert property (sw_wr_i && sw_addr_i == 8'h2F |=>
        crossover_algorithm_select_o[1] == $past(sw_wdata_i[7])) else $error("crossover alias wrong");
    power_quiet_a: assert property (power_down_o[0] |=>
        line_transmit_pair_o[SYM_W-1:0] == '0) else $error("powered down port transmits");
    unmapped_zero_a: assert property (sw_addr_i == 8'h30 |=>
        sw_rdata_o == 8'h00) else $error("unmapped switch read not zero");
    read_turnaround_a: assert property ($rose(mdio_oe_o) |->
        !mdio_o ##0 mdio_oe_o [*8]) else $error("read turnaround wrong");

    cover property (near_loop_o[0]);
    cover property ($rose(mdio_oe_o));
    cover property (autoneg_restart_o[0]);
endmodule // phy_mgmt_register_map_properties

// ==== tb/mdio_master_model.sv ====
// management master model: whole frames on the two-wire link
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/100ps
module mdio_master_model (
    // link outputs
    output logic mdc_o,
    output logic mdio_d_o,
    output logic mdio_en_o,
    // resolved data line
    input wire mdio_i
);
    initial begin
        mdc_o = 1'b0;
        mdio_d_o = 1'b1;
        mdio_en_o = 1'b0;
    end
    // clock stands low between frames; full preamble every frame
    task xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        int i;
        begin
            f = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
            rd = 16'h0000;
            for (i = 63; i >= 0; i--) begin
                mdc_o = 1'b0;
                // released over turnaround and data of a read
                mdio_en_o = !(op == 2'b10 && i < 18);
                mdio_d_o = f[i];
                #40;
                mdc_o = 1'b1;
                if (i < 16) begin
                    rd[i] = mdio_i;
                end
                #40;
            end
            mdc_o = 1'b0;
            mdio_en_o = 1'b0;
        end
    endtask
endmodule // mdio_master_model

// ==== tb/phy_mgmt_register_map_tb_top.sv ====
// self-checking bench for the phy management register view
// assumes the master model and properties checker compiled before it
`timescale 1ns/100ps
module phy_mgmt_register_map_tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sw_wr_i = 1'b0;
    logic [7:0] sw_addr_i = 8'h00;
    logic [7:0] sw_wdata_i = 8'h00;
    logic [9:0] rx = 10'h2A5;
    logic [9:0] mac = 10'h0F3;
    logic [31:0] stat = 32'h7849_7809;
    logic [31:0] part = 32'h45E1_05E1;
    wire mdc, m_d, m_en, dut_o, dut_oe;
    wire [7:0] rdata;
    wire [9:0] tx;
    wire [1:0] near, far, f100, an, rs, pd, fdx, xs, fst;
    int failures = 0;
    int checked = 0;
    logic [15:0] rd;
    // released line is pulled up, so an idle read shows all ones
    wire mdio_w = dut_oe ? dut_o : (m_en ? m_d : 1'b1);

    mdio_master_model mdio_u (.mdc_o(mdc), .mdio_d_o(m_d), .mdio_en_o(m_en), .mdio_i(mdio_w));
    phy_mgmt_register_map #(.SYM_W(5)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dut_o), .mdio_oe_o(dut_oe),
        .sw_wr_i(sw_wr_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_rdata_o(rdata),
        .line_receive_pair_i(rx), .mac_transmit_i(mac), .line_transmit_pair_o(tx),
        .basic_status_i(stat), .partner_ability_i(part), .near_loop_o(near), .far_loop_o(far),
        .force_100_o(f100), .autoneg_on_o(an), .autoneg_restart_o(rs), .power_down_o(pd),
        .full_duplex_o(fdx), .crossover_algorithm_select_o(xs), .force_straight_through_o(fst));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            checked++;
            if (got !== exp) begin
                failures++;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task sw_wr(input logic [7:0] a, input logic [7:0] d);
        begin
            @(posedge clk_i);
            #1 sw_addr_i = a;
            sw_wdata_i = d;
            sw_wr_i = 1'b1;
            @(posedge clk_i);
            #1 sw_wr_i = 1'b0;
        end
    endtask
    task sw_rd(input logic [7:0] a, input logic [7:0] e);
        begin
            @(posedge clk_i);
            #1 sw_addr_i = a;
            @(posedge clk_i);
            #1 chk(16'(rdata), 16'(e));
        end
    endtask
    // frames start just after a clock edge, so link edges never meet clk_i edges
    task mwr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
        begin
            @(posedge clk_i);
            #1 mdio_u.xfer(2'b01, pa, ra, wd, rd);
        end
    endtask
    task mrd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
        begin
            @(posedge clk_i);
            #1 mdio_u.xfer(2'b10, pa, ra, 16'h0000, rd);
            chk(rd, e);
        end
    endtask
    task settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task t_reset;
        begin
            chk(16'({an, xs, pd, far}), 16'h00F0);
            sw_rd(8'h0F, 8'h08);
            sw_rd(8'h1C, 8'h80);
            sw_rd(8'h2F, 8'h80);
            mrd(5'h01, 5'h00, 16'h1020);
            mrd(5'h02, 5'h00, 16'h1020);
            mrd(5'h01, 5'h01, stat[15:0]);
            mrd(5'h02, 5'h05, part[31:16]);
            mrd(5'h01, 5'h04, 16'h0001);
            mrd(5'h01, 5'h02, 16'h0000);
            mwr(5'h02, 5'h1D, 16'h0A5A);
            mrd(5'h02, 5'h1D, 16'h0A5A);
        end
    endtask
    task t_near;
        begin
            sw_wr(8'h1C, 8'hC0);
            sw_wr(8'h2C, 8'hC0);
            sw_wr(8'h1A, 8'h02);
            settle;
            chk(16'(tx), 16'({mac[9:5], rx[4:0]}));
            sw_rd(8'h1A, 8'h02);
            sw_wr(8'h1A, 8'h00);
            mwr(5'h02, 5'h1F, 16'h0002);
            settle;
            chk(16'(near), 16'h0002);
            chk(16'(tx), 16'({rx[9:5], mac[4:0]}));
            sw_rd(8'h2A, 8'h02);
            mwr(5'h02, 5'h1F, 16'h0000);
        end
    endtask
    task t_unsup;
        logic [4:0] ra [3];
        int i;
        begin
            ra = '{5'h06, 5'h10, 5'h1E};
            for (i = 0; i < 3; i++) begin
                mwr(5'h01, ra[i], 16'hFFFF);
                mrd(5'h01, ra[i], 16'h0000);
            end
            chk(16'({far, pd, near}), 16'h0000);
            mrd(5'h03, 5'h00, 16'hFFFF);
            sw_rd(8'h30, 8'h00);
        end
    endtask
    task t_ctrl;
        begin
            mwr(5'h01, 5'h00, 16'hFFFF);
            settle;
            chk(16'(tx), 16'({rx[9:5], 5'h00}));
            chk(16'(fst), 16'h0001);
            mrd(5'h01, 5'h00, 16'h7930);
            sw_rd(8'h1D, 8'h0B);
            sw_rd(8'h1C, 8'hE0);
            sw_rd(8'h1F, 8'h80);
            sw_wr(8'h2F, 8'h00);
            chk(16'(xs), 16'h0001);
            sw_rd(8'h2F, 8'h00);
        end
    endtask
    task t_restart;
        begin
            sw_wr(8'h1D, 8'h20);
            chk(16'(rs), 16'h0001);
            @(posedge clk_i);
            #1 chk(16'(rs), 16'h0000);
            sw_rd(8'h1D, 8'h00);
        end
    endtask
    task t_addr;
        begin
            sw_wr(8'h0F, 8'h28);
            sw_rd(8'h0F, 8'h28);
            mrd(5'h06, 5'h00, 16'h3000);
            mrd(5'h05, 5'h00, 16'h3120);
            mrd(5'h01, 5'h00, 16'hFFFF);
        end
    endtask
    task final_report;
        begin
            $display("checked=%0d failures=%0d", checked, failures);
            if (failures == 0 && checked > 0) begin
                $display("Result: passed");
            end else begin
                $display("Result: failed");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_n_i = 1'b1;
        t_reset;
        t_near;
        t_unsup;
        t_ctrl;
        t_restart;
        t_addr;
        final_report;
    end
    // about 22 frames of 5.1 us each are expected
    initial begin
        #500000;
        failures++;
        final_report;
    end
endmodule // phy_mgmt_register_map_tb_top

bind phy_mgmt_register_map phy_mgmt_register_map_properties #(.SYM_W(SYM_W)) chk_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
    .sw_wr_i(sw_wr_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_rdata_o(sw_rdata_o),
    .line_receive_pair_i(line_receive_pair_i), .line_transmit_pair_o(line_transmit_pair_o),
    .near_loop_o(near_loop_o), .far_loop_o(far_loop_o), .force_100_o(force_100_o),
    .autoneg_on_o(autoneg_on_o), .autoneg_restart_o(autoneg_restart_o),
    .power_down_o(power_down_o), .full_duplex_o(full_duplex_o),
    .crossover_algorithm_select_o(crossover_algorithm_select_o),
    .force_straight_through_o(force_straight_through_o));
